// ---- include/lip_pkg.sv ----
// Purpose: Shared constants and types for the link info and option parser
// Assumes: APB byte addressing, 32-bit data words
// Notes:   Each offset, code and default lives here once
package lip_pkg;
    // ******************************
    // Register byte offsets
    // ******************************
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_STAT  = 8'h04;
    localparam logic [7:0] OFS_IREQ0 = 8'h08;
    localparam logic [7:0] OFS_IREQ1 = 8'h0C;
    localparam logic [7:0] OFS_IRSP0 = 8'h10;
    localparam logic [7:0] OFS_IRSP1 = 8'h14;
    localparam logic [7:0] OFS_IRSP2 = 8'h18;
    localparam logic [7:0] OFS_OPT   = 8'h1C;
    localparam logic [7:0] OFS_CAP   = 8'h20;
    localparam logic [7:0] OFS_CFGR  = 8'h24;
    localparam logic [7:0] OFS_NEG   = 8'h28;
    localparam logic [7:0] OFS_QOS   = 8'h2C;
    // ******************************
    // Packet codes and fields
    // ******************************
    localparam logic [7:0]  CODE_INFO_REQ  = 8'h0A;
    localparam logic [7:0]  CODE_INFO_RSP  = 8'h0B;
    localparam logic [15:0] INFO_REQ_LEN   = 16'h0002;
    localparam logic [15:0] KIND_CL_MTU    = 16'h0001;
    localparam logic [15:0] IRES_SUCCESS   = 16'h0000;
    localparam logic [15:0] IRES_NOT_SUPP  = 16'h0001;
    localparam logic [15:0] IRSP_LEN_DATA  = 16'h0006;
    localparam logic [15:0] IRSP_LEN_EMPTY = 16'h0004;
    localparam logic [7:0]  OPT_MTU        = 8'h01;
    localparam logic [7:0]  OPT_FLUSH      = 8'h02;
    localparam logic [7:0]  OPT_QOS        = 8'h03;
    localparam logic [7:0]  OPT_LEN2       = 8'h02;
    localparam int          OPT_HINT_BIT   = 7;
    localparam logic [15:0] CRES_SUCCESS   = 16'h0000;
    localparam logic [15:0] CRES_UNACCEPT  = 16'h0001;
    localparam logic [15:0] CRES_REJECT    = 16'h0002;
    localparam logic [15:0] CRES_UNKNOWN   = 16'h0003;
    localparam logic [7:0]  SVC_NO_TRAFFIC = 8'h00;
    localparam logic [7:0]  SVC_BEST       = 8'h01;
    localparam logic [7:0]  SVC_GUARANTEED = 8'h02;
    // ******************************
    // Defaults after reset, MTU floor and no-retransmission flush value
    // ******************************
    localparam logic [15:0] MTU_MIN        = 16'd48;
    localparam logic [15:0] MTU_DEFAULT    = 16'd672;
    localparam logic [15:0] FLUSH_NO_RETX  = 16'h0001;
    localparam logic [15:0] FLUSH_DEFAULT  = 16'hFFFF;
    localparam logic [31:0] CAP_RESET      = {MTU_DEFAULT, MTU_DEFAULT};
    // ******************************
    // Carriers
    // ******************************
    typedef struct packed {
        logic [15:0] len;
        logic [7:0]  id;
        logic [7:0]  code;
    } lip_hdr_t;
    typedef struct packed {
        lip_hdr_t    hdr;
        logic [15:0] kind;
    } lip_ireq_t;
    typedef struct packed {
        lip_hdr_t    hdr;
        logic [15:0] result;
        logic [15:0] kind;
        logic [15:0] data;
    } lip_irsp_t;
    typedef struct packed {
        logic [15:0] data;
        logic [7:0]  len;
        logic [7:0]  typ;
    } lip_opt_t;
endpackage

// ---- src/lip_info.sv ----
// Purpose: Builds the answer to one information request
// Assumes: Request held stable while req_valid is high
// Notes:   Answer or drop pulse one cycle after req_valid
`timescale 1ns/1ps
module lip_info (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Request side
    input  wire logic               req_valid,
    input  wire lip_pkg::lip_ireq_t req,
    input  wire logic [15:0]        cl_mtu,
    // Answer side
    output logic                    rsp_valid,
    output lip_pkg::lip_irsp_t      rsp,
    output logic                    drop
);
    // Request checks and answer fields
    wire well  = req.hdr.code == lip_pkg::CODE_INFO_REQ && req.hdr.len == lip_pkg::INFO_REQ_LEN;
    wire known = req.kind == lip_pkg::KIND_CL_MTU;
    lip_pkg::lip_irsp_t next_rsp;
    assign next_rsp.hdr.code = lip_pkg::CODE_INFO_RSP;
    assign next_rsp.hdr.id   = req.hdr.id;
    assign next_rsp.hdr.len  = known ? lip_pkg::IRSP_LEN_DATA : lip_pkg::IRSP_LEN_EMPTY;
    assign next_rsp.kind     = req.kind;
    assign next_rsp.result   = known ? lip_pkg::IRES_SUCCESS : lip_pkg::IRES_NOT_SUPP;
    assign next_rsp.data     = known ? cl_mtu : 16'h0000;

    // Answer register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_valid <= 1'b0;
            drop      <= 1'b0;
            rsp       <= '0;
        end else begin
            rsp_valid <= req_valid & well;
            drop      <= req_valid & ~well;
            if (req_valid && well) begin
                rsp <= next_rsp;
            end
        end
    end
endmodule

// ---- src/lip_opt.sv ----
// Purpose: Parses configuration option elements one at a time
// Assumes: First two payload octets of each element arrive with it
// Notes:   clear restores defaults before a new option list
`timescale 1ns/1ps
module lip_opt (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Option stream
    input  wire logic              clear,
    input  wire logic              opt_valid,
    input  wire lip_pkg::lip_opt_t opt,
    input  wire logic [15:0]       own_mtu,
    // Negotiated values
    output logic [15:0]            mtu,
    output logic [15:0]            flush,
    output logic [7:0]             svc,
    output logic [15:0]            result,
    output logic [7:0]             unk_typ
);
    // Element classification
    wire is_mtu  = opt.typ == lip_pkg::OPT_MTU;
    wire is_fl   = opt.typ == lip_pkg::OPT_FLUSH;
    wire is_qos  = opt.typ == lip_pkg::OPT_QOS;
    wire bad_len = (is_mtu | is_fl) && opt.len != lip_pkg::OPT_LEN2;
    wire hint    = opt.typ[lip_pkg::OPT_HINT_BIT];
    wire too_small = opt.data < lip_pkg::MTU_MIN;
    wire [15:0] min_mtu = opt.data < own_mtu ? opt.data : own_mtu;
    wire [7:0] q_svc = opt.data[15:8];
    wire q_bad  = q_svc != lip_pkg::SVC_BEST && q_svc != lip_pkg::SVC_NO_TRAFFIC;

    // Option state, defaults on clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mtu     <= lip_pkg::MTU_DEFAULT;
            flush   <= lip_pkg::FLUSH_DEFAULT;
            svc     <= lip_pkg::SVC_BEST;
            result  <= lip_pkg::CRES_SUCCESS;
            unk_typ <= 8'h00;
        end else if (clear) begin
            mtu     <= lip_pkg::MTU_DEFAULT;
            flush   <= lip_pkg::FLUSH_DEFAULT;
            svc     <= lip_pkg::SVC_BEST;
            result  <= lip_pkg::CRES_SUCCESS;
            unk_typ <= 8'h00;
        end else if (opt_valid) begin
            if (bad_len) begin
                result <= lip_pkg::CRES_REJECT;
            end else if (is_mtu) begin
                mtu <= too_small ? lip_pkg::MTU_MIN : min_mtu;
                if (too_small) begin
                    result <= lip_pkg::CRES_UNACCEPT;
                end
            end else if (is_fl) begin
                flush <= opt.data;
            end else if (is_qos) begin
                svc <= q_bad ? lip_pkg::SVC_BEST : q_svc;
                if (q_bad) begin
                    result <= lip_pkg::CRES_UNACCEPT;
                end
            end else if (!hint) begin
                result  <= lip_pkg::CRES_UNKNOWN;
                unk_typ <= opt.typ;
            end
        end
    end
endmodule

// ---- src/lip_top.sv ----
// Purpose: APB slave for information answers and option parsing
// Assumes: One clock pclk, asynchronous active-low presetn
// Notes:   No wait states; pready is high in the first access cycle of every APB access
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module lip_top (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    // APB answer
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Negotiated link settings
    output logic             no_retx,
    output logic             unlimited_retx
);
    // ******************************
    // Declarations
    // ******************************
    typedef enum logic [2:0] {
        LIP_IDLE = 3'b001,
        LIP_REQ  = 3'b010,
        LIP_WAIT = 3'b100
    } lip_state_t;

    lip_state_t         state;
    lip_state_t         next_state;
    lip_pkg::lip_ireq_t ireq;
    lip_pkg::lip_opt_t  opt;
    logic [31:0]        cap;
    logic               opt_push;
    logic               opt_clear;
    logic               rsp_seen;
    logic               bad_seen;
    lip_pkg::lip_irsp_t irsp;
    logic               irsp_valid;
    logic               idrop;
    logic [15:0]        mtu;
    logic [15:0]        flush;
    logic [7:0]         svc;
    logic [15:0]        cres;
    logic [7:0]         unk_typ;

    // ******************************
    // APB decode
    // ******************************
    // Access qualification and address hits
    wire setup   = psel & ~penable;
    wire wr_en   = psel & penable & pready & pwrite;
    wire hit_ctl = paddr == lip_pkg::OFS_CTRL;
    wire hit_st  = paddr == lip_pkg::OFS_STAT;
    wire hit_q0  = paddr == lip_pkg::OFS_IREQ0;
    wire hit_q1  = paddr == lip_pkg::OFS_IREQ1;
    wire hit_r0  = paddr == lip_pkg::OFS_IRSP0;
    wire hit_r1  = paddr == lip_pkg::OFS_IRSP1;
    wire hit_r2  = paddr == lip_pkg::OFS_IRSP2;
    wire hit_op  = paddr == lip_pkg::OFS_OPT;
    wire hit_cap = paddr == lip_pkg::OFS_CAP;
    wire hit_cr  = paddr == lip_pkg::OFS_CFGR;
    wire hit_neg = paddr == lip_pkg::OFS_NEG;
    wire hit_qos = paddr == lip_pkg::OFS_QOS;
    wire mapped  = hit_ctl | hit_st | hit_q0 | hit_q1 | hit_r0 | hit_r1 | hit_r2
                 | hit_op | hit_cap | hit_cr | hit_neg | hit_qos;
    wire busy    = state != LIP_IDLE;

    // Write strobes
    wire go_info  = wr_en & hit_ctl & pwdata[0] & ~busy;
    wire go_clear = wr_en & hit_ctl & pwdata[1];
    wire st_clr   = wr_en & hit_st;

    // Read data selection
    wire [31:0] stat_word = {29'h0, busy, bad_seen, rsp_seen};
    wire [31:0] next_rdata =
          hit_st  ? stat_word
        : hit_q0  ? ireq.hdr
        : hit_q1  ? {16'h0000, ireq.kind}
        : hit_r0  ? irsp.hdr
        : hit_r1  ? {irsp.result, irsp.kind}
        : hit_r2  ? {16'h0000, irsp.data}
        : hit_op  ? opt
        : hit_cap ? cap
        : hit_cr  ? {8'h00, unk_typ, cres}
        : hit_neg ? {flush, mtu}
        : hit_qos ? {22'h0, unlimited_retx, no_retx, svc}
        : 32'h0000_0000;

    // Answer registered in setup, shown in access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= setup ? next_rdata : 32'h0000_0000;
        end
    end

    // ******************************
    // Software registers
    // ******************************
    // Request words, capability, option element
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ireq <= '0;
            cap  <= lip_pkg::CAP_RESET;
            opt  <= '0;
        end else begin
            if (wr_en && hit_q0 && !busy) begin
                ireq.hdr <= pwdata;
            end
            if (wr_en && hit_q1 && !busy) begin
                ireq.kind <= pwdata[15:0];
            end
            if (wr_en && hit_cap) begin
                cap <= pwdata;
            end
            if (wr_en && hit_op) begin
                opt <= pwdata;
            end
        end
    end

    // Option push and list clear pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_push  <= 1'b0;
            opt_clear <= 1'b0;
        end else begin
            opt_push  <= wr_en & hit_op;
            opt_clear <= go_clear;
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_seen <= 1'b0;
            bad_seen <= 1'b0;
        end else begin
            rsp_seen <= irsp_valid | (rsp_seen & ~(st_clr & pwdata[0]));
            bad_seen <= idrop | (bad_seen & ~(st_clr & pwdata[1]));
        end
    end

    // ******************************
    // Request sequencer
    // ******************************
    // Next state
    always_comb begin
        next_state = state;
        case (state)
            LIP_IDLE: begin
                if (go_info) begin
                    next_state = LIP_REQ;
                end
            end
            LIP_REQ: begin
                next_state = LIP_WAIT;
            end
            LIP_WAIT: begin
                if (irsp_valid || idrop) begin
                    next_state = LIP_IDLE;
                end
            end
            default: begin
                next_state = LIP_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= LIP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ******************************
    // Engines
    // ******************************
    // Information answer builder
    lip_info lip_info_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .req_valid (state == LIP_REQ),
        .req       (ireq),
        .cl_mtu    (cap[31:16]),
        .rsp_valid (irsp_valid),
        .rsp       (irsp),
        .drop      (idrop)
    );

    // Option parser, own capability bounds reported MTU
    lip_opt lip_opt_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (opt_clear),
        .opt_valid (opt_push),
        .opt       (opt),
        .own_mtu   (cap[15:0]),
        .mtu       (mtu),
        .flush     (flush),
        .svc       (svc),
        .result    (cres),
        .unk_typ   (unk_typ)
    );

    // Retransmission policy from flush timeout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            no_retx        <= 1'b0;
            unlimited_retx <= 1'b1;
        end else begin
            no_retx        <= flush == lip_pkg::FLUSH_NO_RETX;
            unlimited_retx <= flush == lip_pkg::FLUSH_DEFAULT;
        end
    end

    // ******************************
    // Assertions
    // ******************************
    sequence s_req;
        state == LIP_REQ && ireq.hdr.code == lip_pkg::CODE_INFO_REQ
            && ireq.hdr.len == lip_pkg::INFO_REQ_LEN;
    endsequence

    sequence s_known;
        s_req and ireq.kind == lip_pkg::KIND_CL_MTU;
    endsequence

    property p_info_code;
        @(posedge pclk) disable iff (!presetn)
        s_req |=> irsp_valid && irsp.hdr.code == lip_pkg::CODE_INFO_RSP;
    endproperty
    a_info_code: assert property (p_info_code) else $error("no info answer");

    property p_id_copy;
        @(posedge pclk) disable iff (!presetn)
        s_req |=> irsp.hdr.id == $past(ireq.hdr.id);
    endproperty
    a_id_copy: assert property (p_id_copy) else $error("identifier not copied");

    property p_kind_copy;
        @(posedge pclk) disable iff (!presetn)
        s_req |=> irsp.kind == $past(ireq.kind);
    endproperty
    a_kind_copy: assert property (p_kind_copy) else $error("kind not copied");

    property p_not_supp;
        @(posedge pclk) disable iff (!presetn)
        s_req and ireq.kind != lip_pkg::KIND_CL_MTU |=> irsp.result == lip_pkg::IRES_NOT_SUPP
            && irsp.data == 16'h0000 && irsp.hdr.len == lip_pkg::IRSP_LEN_EMPTY;
    endproperty
    a_not_supp: assert property (p_not_supp) else $error("bad not-supported answer");

    property p_mtu_data;
        @(posedge pclk) disable iff (!presetn)
        s_known |=> irsp.result == lip_pkg::IRES_SUCCESS && irsp.data == $past(cap[31:16])
            && irsp.hdr.len == lip_pkg::IRSP_LEN_DATA;
    endproperty
    a_mtu_data: assert property (p_mtu_data) else $error("bad MTU answer");

    property p_mtu_min;
        @(posedge pclk) disable iff (!presetn)
        opt_push && opt.typ == lip_pkg::OPT_MTU && opt.len == lip_pkg::OPT_LEN2
            && opt.data >= lip_pkg::MTU_MIN |=> mtu <= $past(cap[15:0]) && mtu <= $past(opt.data);
    endproperty
    a_mtu_min: assert property (p_mtu_min) else $error("MTU not minimum");

    // Undersized request is raised to the floor and flagged
    property p_mtu_floor;
        @(posedge pclk) disable iff (!presetn)
        opt_push && opt.typ == lip_pkg::OPT_MTU && opt.len == lip_pkg::OPT_LEN2
            && opt.data < lip_pkg::MTU_MIN
            |=> mtu == lip_pkg::MTU_MIN && cres == lip_pkg::CRES_UNACCEPT;
    endproperty
    a_mtu_floor: assert property (p_mtu_floor) else $error("MTU floor not applied");

    // List clear restores default size, flush and best effort
    property p_clear_defaults;
        @(posedge pclk) disable iff (!presetn)
        opt_clear |=> mtu == lip_pkg::MTU_DEFAULT && flush == lip_pkg::FLUSH_DEFAULT
            && svc == lip_pkg::SVC_BEST && cres == lip_pkg::CRES_SUCCESS;
    endproperty
    a_clear_defaults: assert property (p_clear_defaults) else $error("defaults not restored");

    property p_flush_policy;
        @(posedge pclk) disable iff (!presetn)
        flush == lip_pkg::FLUSH_NO_RETX |=> no_retx && !unlimited_retx;
    endproperty
    a_flush_policy: assert property (p_flush_policy) else $error("no-retx not set");

    property p_flush_inf;
        @(posedge pclk) disable iff (!presetn)
        flush == lip_pkg::FLUSH_DEFAULT |=> unlimited_retx && !no_retx;
    endproperty
    a_flush_inf: assert property (p_flush_inf) else $error("unlimited not set");

    property p_hint_skip;
        @(posedge pclk) disable iff (!presetn)
        opt_push && opt.typ[lip_pkg::OPT_HINT_BIT] && !opt_clear
            |=> $stable(cres) && $stable(unk_typ);
    endproperty
    a_hint_skip: assert property (p_hint_skip) else $error("hint changed result");

    property p_apb_wait;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("APB answer timing");
endmodule

// ---- tb/lip_remote.sv ----
// Purpose: Remote entity forming information request words
// Assumes: Bench picks identifier, kind and length
// Notes:   Code is always the request code
`timescale 1ns/1ps
module lip_remote (
    // Request choice
    input  wire logic [7:0]  id,
    input  wire logic [15:0] kind,
    input  wire logic [15:0] len,
    // Register words
    output logic [31:0]      ireq0,
    output logic [31:0]      ireq1
);
    lip_pkg::lip_ireq_t req;
    // Request fields packed for the device
    assign req = '{hdr: '{len: len, id: id, code: lip_pkg::CODE_INFO_REQ}, kind: kind};
    assign ireq0 = req.hdr;
    assign ireq1 = {16'h0000, req.kind};
endmodule

// ---- tb/lip_top_bench.sv ----
// Purpose: Self-checking bench for the info and option block
// Assumes: Zero wait states per APB access
// Notes:   All traffic goes through APB tasks
`timescale 1ns/1ps
module lip_top_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, no_retx, unl;
    logic [7:0]  paddr, id;
    logic [31:0] pwdata, prdata, rd, ireq0, ireq1;
    logic [15:0] kind, len;
    logic        err;
    int mismatches, cmp_count, cycles;

    lip_top lip_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .no_retx(no_retx), .unlimited_retx(unl));
    lip_remote lip_remote_i (.id(id), .kind(kind), .len(len), .ireq0(ireq0), .ireq1(ireq1));

    // ************
    // Bus and compare tasks
    // ************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic send(input logic [7:0] i, input logic [15:0] k, input logic [15:0] l);
        id = i; kind = k; len = l;
        apb(1'b1, lip_pkg::OFS_STAT, 32'h3);
        apb(1'b1, lip_pkg::OFS_IREQ0, ireq0);
        apb(1'b1, lip_pkg::OFS_IREQ1, ireq1);
        apb(1'b1, lip_pkg::OFS_CTRL, 32'h1);
        for (int n = 0; n < 20; n++) begin
            apb(1'b0, lip_pkg::OFS_STAT, 32'h0);
            if (rd[1:0] !== 2'b00) break;
        end
    endtask
    task automatic opt(input logic [31:0] w);
        apb(1'b1, lip_pkg::OFS_OPT, w);
        @(posedge pclk); // Parse edge, then policy flops settle
    endtask

    // ************
    // Scenarios
    // ************
    task automatic t_reset;
        chk({no_retx, unl}, 2'b01);
        rchk(lip_pkg::OFS_CAP, 32'h02A0_02A0);
        rchk(lip_pkg::OFS_NEG, 32'hFFFF_02A0);
        rchk(lip_pkg::OFS_QOS, 32'h0000_0201);
    endtask
    task automatic t_info;
        send(8'h5A, 16'h0001, 16'h0002);
        chk(rd[1:0], 2'b01);
        rchk(lip_pkg::OFS_IRSP0, 32'h0006_5A0B);
        rchk(lip_pkg::OFS_IRSP1, 32'h0000_0001);
        rchk(lip_pkg::OFS_IRSP2, 32'h0000_02A0);
        send(8'hC3, 16'h0007, 16'h0002);
        rchk(lip_pkg::OFS_IRSP0, 32'h0004_C30B);
        rchk(lip_pkg::OFS_IRSP1, 32'h0001_0007);
        rchk(lip_pkg::OFS_IRSP2, 32'h0000_0000);
        send(8'h11, 16'h0001, 16'h0003);
        chk(rd[1:0], 2'b10);
        rchk(lip_pkg::OFS_IRSP0, 32'h0004_C30B);
    endtask
    task automatic t_mtu;
        apb(1'b1, lip_pkg::OFS_CAP, 32'h02A0_0064);
        apb(1'b1, lip_pkg::OFS_CTRL, 32'h2);
        opt(32'h00C8_0201);
        rchk(lip_pkg::OFS_NEG, 32'hFFFF_0064);
        rchk(lip_pkg::OFS_CFGR, 32'h0);
        opt(32'h0028_0201);
        rchk(lip_pkg::OFS_NEG, 32'hFFFF_0030);
        rchk(lip_pkg::OFS_CFGR, 32'h1);
        opt(32'h0040_0301);
        rchk(lip_pkg::OFS_CFGR, 32'h2);
    endtask
    task automatic t_flush;
        apb(1'b1, lip_pkg::OFS_CTRL, 32'h2);
        opt(32'h0001_0202);
        rchk(lip_pkg::OFS_QOS, 32'h0000_0101);
        chk({no_retx, unl}, 2'b10);
        opt(32'hFFFF_0202);
        rchk(lip_pkg::OFS_NEG, 32'hFFFF_02A0);
        chk({no_retx, unl}, 2'b01);
    endtask
    task automatic t_qos;
        logic [7:0] s;
        apb(1'b1, lip_pkg::OFS_CTRL, 32'h2);
        for (int k = 0; k < 3; k++) begin
            s = 8'(k);
            opt({s, 8'h00, 8'h16, 8'h03});
            rchk(lip_pkg::OFS_QOS, {22'h0, 2'b10, (k == 2) ? 8'h01 : s});
            rchk(lip_pkg::OFS_CFGR, (k == 2) ? 32'h1 : 32'h0);
        end
    endtask
    task automatic t_unknown;
        apb(1'b1, lip_pkg::OFS_CTRL, 32'h2);
        opt(32'h0000_0085);
        rchk(lip_pkg::OFS_CFGR, 32'h0);
        opt(32'h0000_0005);
        rchk(lip_pkg::OFS_CFGR, 32'h0005_0003);
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
    endtask

    // ************
    // Clock, timeout and closing
    // ************
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Cut a hang short
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    // Main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; id = 8'h00; kind = 16'h0; len = 16'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_info();
        t_mtu();
        t_flush();
        t_qos();
        t_unknown();
        summarize();
    end
endmodule
